/* File: rtl/csc_regs.svh */
// Constants for the clock synthesizer control block: offsets, fields, counts.
// Assumes inclusion by the control module and its bench only.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
// ********************************
// Register offsets
// ********************************
`define CSC_OFF_CTRL0 8'h00
`define CSC_OFF_FREQ 8'h04
`define CSC_OFF_WDOG 8'h0c
`define CSC_OFF_FBDIV 8'h0d
`define CSC_OFF_REFDIV 8'h0e
// ********************************
// Fields and reset values
// ********************************
`define CSC_CTRL0_PCIRUN 3
`define CSC_WD_PINSEL 7
`define CSC_WD_REVERT 6
`define CSC_WD_ALARM 4
`define CSC_REFDIV_GATE 0
`define CSC_SEL_SET 7
`define CSC_RST_CTRL0 8'hff
`define CSC_RST_WDOG 8'h80
`define CSC_RST_ZERO 8'h00
// ********************************
// Loop constants
// ********************************
`define CSC_P_A 27'd95996900
`define CSC_P_B 27'd76797520
`define CSC_P_C 27'd63997933
`define CSC_P_D 27'd127995867
// ********************************
// Timing: 250 MHz clock, 1 s tick, 3.0 ms restart, reset pulse
// ********************************
`define CSC_CLK_HZ 250000000
`define CSC_SEC_NS 1000000000
`define CSC_WAKE_US 3000
`define CSC_WAKE_SLACK 16
`define CSC_PULSE_CYC 8'd250
`endif

/* File: rtl/csc_pkg.sv */
// Types shared by the clock synthesizer control block.
// Assumes the register header sits beside it.
package csc_pkg;
   typedef enum logic [1:0] {
      CSC_WD_IDLE = 2'b00,
      CSC_WD_ARMED = 2'b01,
      CSC_WD_REBOOT = 2'b11
   } csc_wd_t;
   typedef enum logic [1:0] {
      CSC_DOWN = 2'b00,
      CSC_CENTER = 2'b01
   } csc_spread_t;
endpackage

/* File: rtl/csc_ctrl.sv */
// Control logic of a multi-output clock synthesizer: dividers, watchdog,
// output halting and power-down. Assumes a byte-wide register port driven
// by the management-bus slave and clock phase enables from the output stage.
`timescale 1ns/1ps
`include "csc_regs.svh"

module csc_ctrl #(
   parameter int unsigned SEC_CYCLES = `CSC_CLK_HZ,
   parameter int unsigned WAKE_CYCLES = `CSC_CLK_HZ / 1000000 * `CSC_WAKE_US - `CSC_WAKE_SLACK
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WRITE,
   output logic [7:0] REG_RDATA,
   input wire logic [4:0] FREQ_SELECT_STRAPS,
   input wire logic CPU_FALL_EN,
   input wire logic CPU_COMPLEMENT_OUT_RISE_EN,
   input wire logic PCI_FALL_EN,
   input wire logic CPU_CLOCK_HALT_N,
   input wire logic SHARED_PIN_IN,
   output logic SHARED_PIN_OUT,
   output logic SHARED_PIN_OE_N,
   input wire logic POWER_DOWN_N,
   input wire logic TERM_VOLTAGE_GOOD,
   input wire logic [1:0] CPU_STOPPABLE,
   input wire logic PCI_FREE_RUN,
   output logic [6:0] ACTIVE_FB_DIV,
   output logic [5:0] ACTIVE_REF_DIV,
   output logic [26:0] LOOP_CONSTANT,
   output csc_pkg::csc_spread_t SPREAD_MODE,
   output logic [1:0] SPREAD_DEPTH,
   output logic [4:0] ACTIVE_FREQ_SEL,
   output logic [1:0] CPU_RUN,
   output logic [1:0] CPU_COMP_DRIVE,
   output logic PCI_RUN,
   output logic PCI_FREE_RUN_EN,
   output logic OUTPUTS_RUN,
   output logic CPU_DOUBLE_CURRENT,
   output logic PLL_POWER_ON
);
   import csc_pkg::*;

   // ********************************
   // Registers
   // ********************************
   logic [7:0] ctrl0_q, freq_q, wdog_q, fbdiv_q, refdiv_q;
   logic [7:0] prev_freq_q, last_freq_q;
   logic alarm_q, fallback_q;
   logic pci_pin;
   logic [4:0] strap_s1_q, strap_q;
   logic [1:0] pd_sync_q, cpu_sync_q, pci_sync_q;
   logic [1:0] cpu_stop_q;
   logic pd_s1_q, pd_hold_q, pci_stop_q;
   csc_wd_t wd_state_q;
   logic [27:0] sec_cnt_q;
   logic [3:0] wd_cnt_q;
   logic [7:0] pulse_q;
   logic [21:0] wake_q;
   logic sec_tick, wd_expire, freq_change;
   logic wd_off;

   function automatic logic wr_to(input logic [7:0] a, input logic [7:0] off);
      return REG_WRITE && (a == off);
   endfunction

   assign wd_off = (REG_WDATA[3:0] == 4'h0);
   // A change request comes from the strap-style select or an open-gate divider write
   assign freq_change = wr_to(REG_ADDR, `CSC_OFF_FREQ) ||
      (wr_to(REG_ADDR, `CSC_OFF_REFDIV) && REG_WDATA[`CSC_REFDIV_GATE]);

   // Register writes; reserved bit 7 of dividers kept zero
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl0_q <= `CSC_RST_CTRL0;
         freq_q <= `CSC_RST_ZERO;
         fbdiv_q <= `CSC_RST_ZERO;
         refdiv_q <= `CSC_RST_ZERO;
      end else begin
         if (wr_to(REG_ADDR, `CSC_OFF_CTRL0)) ctrl0_q <= REG_WDATA;
         if (wr_to(REG_ADDR, `CSC_OFF_FREQ)) freq_q <= {3'h0, REG_WDATA[4:0]};
         if (wr_to(REG_ADDR, `CSC_OFF_FBDIV)) fbdiv_q <= {1'b0, REG_WDATA[6:0]};
         if (wr_to(REG_ADDR, `CSC_OFF_REFDIV)) refdiv_q <= {1'b0, REG_WDATA[6:0]};
      end
   end

   // Watchdog register; alarm set by expiry wins over software write
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         wdog_q <= `CSC_RST_WDOG;
         alarm_q <= 1'b0;
      end else begin
         if (wr_to(REG_ADDR, `CSC_OFF_WDOG)) wdog_q <= {REG_WDATA[7:6], 2'b00, REG_WDATA[3:0]};
         if (wd_expire) alarm_q <= 1'b1;
         else if (wr_to(REG_ADDR, `CSC_OFF_WDOG) && wd_off) alarm_q <= 1'b0;
      end
   end

   // Active dividers follow programmed values only while the gate is open
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ACTIVE_FB_DIV <= 7'h00;
         ACTIVE_REF_DIV <= 6'h00;
      end else if (refdiv_q[`CSC_REFDIV_GATE]) begin
         ACTIVE_FB_DIV <= fbdiv_q[6:0];
         ACTIVE_REF_DIV <= refdiv_q[6:1];
      end
   end

   // Straps are pins, so they pass two flops like the power-down, CPU halt and shared pin inputs
   always_ff @(posedge CLOCK) begin
      strap_s1_q <= FREQ_SELECT_STRAPS;
      strap_q <= strap_s1_q;
   end

   // Software setting history for revert; strap fallback otherwise
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         prev_freq_q <= `CSC_RST_ZERO;
         last_freq_q <= `CSC_RST_ZERO;
         fallback_q <= 1'b0;
      end else begin
         if (wr_to(REG_ADDR, `CSC_OFF_FREQ)) begin
            prev_freq_q <= last_freq_q;
            last_freq_q <= {1'b1, 2'h0, REG_WDATA[4:0]};
         end
         // Expiry wins over a same-cycle select write, so a reboot is never lost
         if (wd_expire && wd_state_q == CSC_WD_REBOOT) fallback_q <= 1'b1;
         else if (wr_to(REG_ADDR, `CSC_OFF_FREQ)) fallback_q <= 1'b0;
      end
   end

   // Marker bit tells a real software setting apart from the all-zero code
   always_comb begin
      if (fallback_q) ACTIVE_FREQ_SEL = wdog_q[`CSC_WD_REVERT] ? prev_freq_q[4:0] : strap_q;
      else if (last_freq_q[`CSC_SEL_SET]) ACTIVE_FREQ_SEL = last_freq_q[4:0];
      else ACTIVE_FREQ_SEL = strap_q;
   end

   // Loop constant lookup from strap code
   always_comb begin
      unique case (strap_q)
         5'h00, 5'h01, 5'h02, 5'h07, 5'h09, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h14, 5'h16:
            LOOP_CONSTANT = `CSC_P_A;
         5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h19, 5'h1b:
            LOOP_CONSTANT = `CSC_P_C;
         5'h03, 5'h13:
            LOOP_CONSTANT = `CSC_P_D;
         default:
            LOOP_CONSTANT = `CSC_P_B;
      endcase
   end

   // Spread field lives in control 0 bits 2:0; top bit picks center
   assign SPREAD_MODE = ctrl0_q[2] ? CSC_CENTER : CSC_DOWN;
   assign SPREAD_DEPTH = ctrl0_q[1:0];

   // ********************************
   // Watchdog
   // ********************************
   // One-second tick, restarted with the timer
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) sec_cnt_q <= 28'h000_0000;
      else if (freq_change || wd_expire || sec_tick) sec_cnt_q <= 28'h000_0000;
      else if (wd_state_q != CSC_WD_IDLE) sec_cnt_q <= sec_cnt_q + 28'h000_0001;
   end
   assign sec_tick = (sec_cnt_q == 28'(SEC_CYCLES - 1));
   assign wd_expire = (wd_state_q != CSC_WD_IDLE) && sec_tick &&
      (wd_cnt_q + 4'h1 == wdog_q[3:0]);

   // Timer state: start after change, off when stamp cleared
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         wd_state_q <= CSC_WD_IDLE;
         wd_cnt_q <= 4'h0;
      end else if (wr_to(REG_ADDR, `CSC_OFF_WDOG) && wd_off) begin
         wd_state_q <= CSC_WD_IDLE;
         wd_cnt_q <= 4'h0;
      end else if (freq_change && wdog_q[3:0] != 4'h0) begin
         wd_state_q <= CSC_WD_ARMED;
         wd_cnt_q <= 4'h0;
      end else if (wd_expire) begin
         wd_state_q <= CSC_WD_REBOOT;
         wd_cnt_q <= 4'h0;
      end else if (sec_tick && wd_state_q != CSC_WD_IDLE) begin
         wd_cnt_q <= wd_cnt_q + 4'h1;
      end
   end

   // Low reset pulse on each expiry
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) pulse_q <= 8'h00;
      else if (wd_expire) pulse_q <= `CSC_PULSE_CYC;
      else if (pulse_q != 8'h00) pulse_q <= pulse_q - 8'h01;
   end
   // Shared pin: input when bit 7 set, else reset output
   assign SHARED_PIN_OE_N = wdog_q[`CSC_WD_PINSEL];
   assign SHARED_PIN_OUT = (pulse_q == 8'h00);

   // ********************************
   // Pin synchronizers
   // ********************************
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pd_sync_q <= 2'b11;
         cpu_sync_q <= 2'b11;
         pci_sync_q <= 2'b11;
      end else begin
         pd_sync_q <= {pd_sync_q[0], POWER_DOWN_N};
         cpu_sync_q <= {cpu_sync_q[0], CPU_CLOCK_HALT_N};
         pci_sync_q <= {pci_sync_q[0], SHARED_PIN_IN};
      end
   end
   // Pin only counts as PCI halt when configured as input
   assign pci_pin = pci_sync_q[1] | ~wdog_q[`CSC_WD_PINSEL];

   // Halt needs two falling-edge samples; release clears both stages at once,
   // since a second stage on release would overrun the two-cycle resume limit
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) cpu_stop_q <= 2'b00;
      else if (CPU_FALL_EN) cpu_stop_q <= cpu_sync_q[1] ? 2'b00 : {cpu_stop_q[0], 1'b1};
   end
   // Stopped: true held high by run logic, complement undriven
   assign CPU_RUN = ~(CPU_STOPPABLE & {2{cpu_stop_q[1]}}) & {2{OUTPUTS_RUN}};
   assign CPU_COMP_DRIVE = CPU_RUN;

   // PCI stop taken on PCI falling edge so no short pulse
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) pci_stop_q <= 1'b0;
      else if (PCI_FALL_EN) pci_stop_q <= ~(pci_pin & ctrl0_q[`CSC_CTRL0_PCIRUN]);
   end
   assign PCI_RUN = ~pci_stop_q & OUTPUTS_RUN;
   assign PCI_FREE_RUN_EN = PCI_FREE_RUN & OUTPUTS_RUN;

   // Power-down: two complement-rising samples, hold set on the second rise
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pd_s1_q <= 1'b0;
         pd_hold_q <= 1'b0;
      end else if (CPU_COMPLEMENT_OUT_RISE_EN) begin
         pd_s1_q <= ~pd_sync_q[1];
         pd_hold_q <= pd_s1_q & ~pd_sync_q[1];
      end
   end
   assign CPU_DOUBLE_CURRENT = pd_hold_q;

   // Restart counter after release, 16 cycles short of 3.0 ms
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) wake_q <= 22'h00_0000;
      else if (pd_hold_q) wake_q <= 22'(WAKE_CYCLES - 1);
      else if (wake_q != 22'h00_0000) wake_q <= wake_q - 22'h00_0001;
   end
   assign OUTPUTS_RUN = ~pd_hold_q && (wake_q == 22'h00_0000);
   assign PLL_POWER_ON = ~pd_hold_q;

   // Readback; PCI run bit reports the AND of pin and bit unused input
   always_comb begin
      unique case (REG_ADDR)
         `CSC_OFF_CTRL0: REG_RDATA = {ctrl0_q[7:4],
            ctrl0_q[`CSC_CTRL0_PCIRUN] & pci_pin, ctrl0_q[2:0]};
         `CSC_OFF_FREQ: REG_RDATA = freq_q;
         `CSC_OFF_WDOG: REG_RDATA = {wdog_q[7:5], alarm_q, wdog_q[3:0]};
         `CSC_OFF_FBDIV: REG_RDATA = fbdiv_q;
         `CSC_OFF_REFDIV: REG_RDATA = refdiv_q;
         default: REG_RDATA = `CSC_RST_ZERO;
      endcase
   end

   // ********************************
   // Assertions
   // ********************************
   rsvd_zero_a: assert property (@(posedge CLOCK) disable iff (RST) !fbdiv_q[7] && !refdiv_q[7])
      else $error("reserved divider bit set");
   gate_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      !refdiv_q[0] |=> $stable(ACTIVE_FB_DIV))
      else $error("divider moved with gate closed");
   expire_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
      wd_expire |=> !SHARED_PIN_OUT && alarm_q)
      else $error("expiry without pulse and alarm");
   clear_off_a: assert property (@(posedge CLOCK) disable iff (RST)
      (wr_to(REG_ADDR, `CSC_OFF_WDOG) && wd_off && !wd_expire) |=> !alarm_q && wd_state_q == CSC_WD_IDLE)
      else $error("clear did not stop watchdog");
   arm_a: assert property (@(posedge CLOCK) disable iff (RST)
      (freq_change && wdog_q[3:0] != 4'h0 && !wr_to(REG_ADDR, `CSC_OFF_WDOG)) |=> wd_state_q == CSC_WD_ARMED)
      else $error("watchdog not started");
   second_fb_a: assert property (@(posedge CLOCK) disable iff (RST)
      (wd_expire && wd_state_q == CSC_WD_REBOOT) |=> fallback_q)
      else $error("no fallback on second expiry");
   pci_read_a: assert property (@(posedge CLOCK) disable iff (RST)
      (REG_ADDR == `CSC_OFF_CTRL0 && !pci_pin) |-> !REG_RDATA[3])
      else $error("pci run readback wrong");
   pd_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
      pd_hold_q |-> !OUTPUTS_RUN && !PLL_POWER_ON && CPU_RUN == 2'b00)
      else $error("outputs running in power down");
   pin_dir_a: assert property (@(posedge CLOCK) disable iff (RST)
      SHARED_PIN_OE_N == wdog_q[7])
      else $error("shared pin direction wrong");
   expire_c: cover property (@(posedge CLOCK) disable iff (RST) wd_expire);
   fallback_c: cover property (@(posedge CLOCK) disable iff (RST) $rose(fallback_q));
   cpu_stop_c: cover property (@(posedge CLOCK) disable iff (RST) $fell(CPU_RUN[0]));
   pd_c: cover property (@(posedge CLOCK) disable iff (RST) $rose(pd_hold_q));
endmodule

/* File: tb/csc_chipset_model.sv */
// Chipset and output-stage stand-in: clock phase markers and halt pins.
// Assumes the bench raises halt or power-down requests at the falling edge.
`timescale 1ns/1ps
module csc_chipset_model (
   input wire logic clk,
   input wire logic cpu_halt_req,
   input wire logic pci_halt_req,
   input wire logic pd_req,
   output logic cpu_fall_en,
   output logic cpu_complement_out_rise_en,
   output logic pci_fall_en,
   output logic cpu_halt_n,
   output logic pci_halt_n,
   output logic power_down_n
);
   // ****************
   // Phase markers
   // ****************
   logic [2:0] ph_q = 3'h0;
   // CPU period four cycles, PCI eight; markers move off the sampling edge
   always @(negedge clk) begin
      ph_q <= ph_q + 3'h1;
      cpu_fall_en <= (ph_q[1:0] == 2'h3);
      cpu_complement_out_rise_en <= (ph_q[1:0] == 2'h1);
      pci_fall_en <= (ph_q == 3'h7);
   end
   // Pins are asynchronous to the device, so they land between edges
   assign #1.3 cpu_halt_n = !cpu_halt_req;
   assign #0.7 pci_halt_n = !pci_halt_req;
   assign #1.1 power_down_n = !pd_req;
endmodule

/* File: tb/clock_synth_control_watchdog_test.sv */
// Self-checking bench for the synthesizer control block.
// Assumes the chipset model supplies phase markers and halt pins.
`timescale 1ns/1ps
`include "csc_regs.svh"
module clock_synth_control_watchdog_test;
   import csc_pkg::*;
   localparam int unsigned SEC = 40;
   localparam int unsigned WAKE = 10;
   logic clock = 0, rst = 1, reg_write = 0, term_good = 0, free_run = 1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fb, rf;
   logic [4:0] straps = 5'h00, sel_a, sel_b;
   logic cpu_req = 0, pci_req = 0, pd_req = 0, low_seen;
   wire [7:0] reg_rdata;
   wire cfe, cre, pfe, cpu_halt_n, pci_halt_n, pd_n, pin_out, pin_oe_n, pin_level;
   wire pci_run, pci_free_run_en, outputs_run, cpu_double_current, pll_power_on;
   wire [6:0] active_fb_div;
   wire [5:0] active_ref_div;
   wire [26:0] loop_constant;
   csc_spread_t spread_mode;
   wire [1:0] spread_depth, cpu_run, cpu_comp_drive;
   wire [4:0] active_freq_sel;
   int errors = 0;
   int n_compared = 0;
   int mreg [int];
   int n;
   // Shared pin: device drive wins, otherwise the chipset level (pulled up)
   assign pin_level = !pin_oe_n ? pin_out : pci_halt_n;
   csc_ctrl #(.SEC_CYCLES(SEC), .WAKE_CYCLES(WAKE)) u_csc_ctrl (
      .CLOCK(clock), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WRITE(reg_write), .REG_RDATA(reg_rdata), .FREQ_SELECT_STRAPS(straps),
      .CPU_FALL_EN(cfe), .CPU_COMPLEMENT_OUT_RISE_EN(cre), .PCI_FALL_EN(pfe),
      .CPU_CLOCK_HALT_N(cpu_halt_n), .SHARED_PIN_IN(pin_level),
      .SHARED_PIN_OUT(pin_out), .SHARED_PIN_OE_N(pin_oe_n), .POWER_DOWN_N(pd_n),
      .TERM_VOLTAGE_GOOD(term_good), .CPU_STOPPABLE(2'b01), .PCI_FREE_RUN(free_run),
      .ACTIVE_FB_DIV(active_fb_div), .ACTIVE_REF_DIV(active_ref_div),
      .LOOP_CONSTANT(loop_constant), .SPREAD_MODE(spread_mode),
      .SPREAD_DEPTH(spread_depth), .ACTIVE_FREQ_SEL(active_freq_sel),
      .CPU_RUN(cpu_run), .CPU_COMP_DRIVE(cpu_comp_drive), .PCI_RUN(pci_run),
      .PCI_FREE_RUN_EN(pci_free_run_en), .OUTPUTS_RUN(outputs_run),
      .CPU_DOUBLE_CURRENT(cpu_double_current), .PLL_POWER_ON(pll_power_on));
   csc_chipset_model u_csc_chipset_model (.clk(clock), .cpu_halt_req(cpu_req),
      .pci_halt_req(pci_req), .pd_req(pd_req), .cpu_fall_en(cfe), .cpu_complement_out_rise_en(cre),
      .pci_fall_en(pfe), .cpu_halt_n(cpu_halt_n), .pci_halt_n(pci_halt_n),
      .power_down_n(pd_n));
   // ****************
   // Clock, noise and helpers
   // ****************
   initial forever #2 clock = ~clock;
   // Power-good input toggles at random all run long
   always @(negedge clock) term_good <= 1'($urandom);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One-cycle write strobe; the model keeps only the stored bits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1;
      @(negedge clock);
      reg_write = 0;
      if (a == 8'h0d || a == 8'h0e) mreg[a] = d & 8'h7f;
      if (a == 8'h0c) mreg[a] = d & 8'hcf;
      if (a == 8'h00) mreg[a] = d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock);
      reg_addr = a;
      #1;
      check(reg_rdata, exp);
   endtask
   // Bounded wait on one watched output; running out ends the run
   task automatic wait_sig(input int w, input logic v, input int bound, output int k);
      logic s;
      k = 0;
      do begin
         @(negedge clock);
         k++;
         case (w)
            0: s = pin_out;
            1: s = pci_run;
            2: s = cpu_run[0];
            default: s = outputs_run;
         endcase
      end while (s !== v && k < bound);
      if (s !== v) begin
         check(s, v);
         tally_and_finish();
      end
   endtask
   function automatic logic [26:0] p_of(input logic [4:0] c);
      case (c)
         5'h00, 5'h01, 5'h02, 5'h07, 5'h09, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h14,
         5'h16: p_of = `CSC_P_A;
         5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0d, 5'h19, 5'h1b: p_of = `CSC_P_C;
         5'h03, 5'h13: p_of = `CSC_P_D;
         default: p_of = `CSC_P_B;
      endcase
   endfunction
   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(32'ha925_669a));
      mreg[8'h00] = 8'hff;
      mreg[8'h0c] = 8'h80;
      mreg[8'h0d] = 8'h00;
      mreg[8'h0e] = 8'h00;
      repeat (2) @(negedge clock);
      rst = 0;
      foreach (mreg[a]) rd(a[7:0], mreg[a][7:0]);
      rd(8'h33, 8'h00);
      check(pin_oe_n, 1'b1);
      fb = 8'($urandom);
      rf = 8'($urandom);
      // Pair written with the gate shut, both halves together
      wr(8'h0d, fb | 8'h80);
      wr(8'h0e, (rf & 8'hfe) | 8'h80);
      rd(8'h0d, mreg[8'h0d][7:0]);
      rd(8'h0e, mreg[8'h0e][7:0]);
      check({active_fb_div, active_ref_div}, 13'h0000);
      wr(8'h0d, fb);
      wr(8'h0e, rf | 8'h01);
      @(negedge clock);
      check({active_fb_div, active_ref_div}, {fb[6:0], rf[6:1]});
      wr(8'h0d, fb);
      wr(8'h0e, rf & 8'hfe);
      wr(8'h0d, ~fb);
      wr(8'h0e, ~rf & 8'hfe);
      check({active_fb_div, active_ref_div}, {fb[6:0], rf[6:1]});
      for (int c = 0; c < 32; c++) begin
         straps = c[4:0];
         repeat (2) @(negedge clock);
         check(loop_constant, p_of(c[4:0]));
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h00, {5'h1f, c[2:0]});
         check(spread_mode, c[2] ? CSC_CENTER : CSC_DOWN);
         check(spread_depth, c[1:0]);
      end
      wr(8'h00, 8'hf7);
      wait_sig(1, 1'b0, 20, n);
      check(pci_free_run_en, 1'b1);
      wr(8'h00, 8'hff);
      wait_sig(1, 1'b1, 16, n);
      pci_req = 1;
      wait_sig(1, 1'b0, 20, n);
      rd(8'h00, 8'hf7);
      pci_req = 0;
      wait_sig(1, 1'b1, 16, n);
      cpu_req = 1;
      wait_sig(2, 1'b0, 16, n);
      check({cpu_run, cpu_comp_drive}, 4'ha);
      cpu_req = 0;
      wait_sig(2, 1'b1, 8, n);
      pd_req = 1;
      wait_sig(3, 1'b0, 16, n);
      check({cpu_double_current, pll_power_on}, 2'b10);
      pd_req = 0;
      wait_sig(3, 1'b1, WAKE + 12, n);
      straps = 5'($urandom);
      sel_a = straps ^ 5'h0a;
      sel_b = straps ^ 5'h15;
      // Stamp cleared in time: no reset pulse, new select kept
      wr(8'h0c, 8'h08);
      check(pin_oe_n, 1'b0);
      wr(8'h04, {3'h0, sel_b});
      repeat (4 * SEC) @(negedge clock);
      wr(8'h0c, 8'h00);
      low_seen = 0;
      repeat (10 * SEC) @(negedge clock) low_seen |= !pin_out;
      check({low_seen, active_freq_sel}, {1'b0, sel_b});
      for (int r = 1; r >= 0; r--) begin
         wr(8'h04, {3'h0, sel_a});
         wr(8'h0c, {1'b0, r[0], 6'h08}); // stamp first
         wr(8'h04, {3'h0, sel_b});
         check(active_freq_sel, sel_b);
         for (int k = 0; k < 2; k++) begin
            wait_sig(0, 1'b0, 9 * SEC, n);
            if (k == 0) check(n, 8 * SEC);
            wait_sig(0, 1'b1, 300, n);
            check(n, `CSC_PULSE_CYC);
            rd(8'h0c, {1'b0, r[0], 6'h18});
            check(active_freq_sel, k ? (r ? sel_a : straps) : sel_b);
         end
         wr(8'h0c, {1'b0, r[0], 6'h00});
         rd(8'h0c, mreg[8'h0c][7:0]);
      end
      tally_and_finish();
   end
endmodule
